// [hw/steer_consts.svh]
`ifndef STEER_CONSTS_SVH
`define STEER_CONSTS_SVH

// APB register map, byte addresses.
`define ADDR_CONTROL 12'h000
`define ADDR_STATUS 12'h004

// Control register fields.
`define CTL_DELAY_LSB 0
`define CTL_DELAY_MSB 6
`define CTL_MODE_LSB 8
`define CTL_MODE_MSB 9
`define CTL_DIR_BIT 10
`define CTL_ACTIVE_LOW_BIT 11

// Status register fields.
`define STA_OUT_LSB 0
`define STA_OUT_MSB 3
`define STA_DELAY_BUSY_BIT 4

// Reset values and answers.
`define CONTROL_RESET 32'h0000_0000
`define UNMAPPED_DATA 32'h0000_0000

`endif

// [hw/steer_pkg.sv]
package steer_pkg;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_HALF,
        MODE_FULL
    } steer_mode_t;

    typedef struct packed {
        logic [6:0] delay;
        steer_mode_t mode;
        logic reverse;
        logic activeLow;
    } steer_cfg_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } steer_pins_t;

endpackage

// [hw/deadband_delay.sv]
`timescale 1ns/1ps
`include "steer_consts.svh"

module deadband_delay #(
    parameter int DELAY_WIDTH = 7
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Request level and programmed delay.
    input wire logic request,
    input wire logic [DELAY_WIDTH-1:0] delay,
    // Delayed level and counter activity.
    output logic delayed,
    output logic busy
);
    typedef struct packed {
        logic [DELAY_WIDTH-1:0] count;
        logic delayed;
        logic busy;
    } dly_state_t;

    dly_state_t state;
    dly_state_t next_state;

    initial
    begin
        if (DELAY_WIDTH < 1 || DELAY_WIDTH > 16)
        begin
            $error("deadband_delay: DELAY_WIDTH out of range");
        end
    end

    // Only the rising edge is delayed; a falling request drops the output at once,
    // so a request shorter than the delay never shows and the output stays inactive.
    always_comb
    begin
        next_state = state;
        if (!request)
        begin
            next_state.count = '0;
            next_state.delayed = 1'b0;
            next_state.busy = 1'b0;
        end
        else if (!state.delayed)
        begin
            if (state.count >= delay)
            begin
                next_state.delayed = 1'b1;
                next_state.busy = 1'b0;
            end
            else
            begin
                next_state.count = state.count + 1'b1;
                next_state.busy = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign delayed = state.delayed;
    assign busy = state.busy;

    delay_release_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(delayed) |-> $past(request, 1) && $past(state.count, 1) >= $past(delay, 1))
        else $error("delayed output rose before the count reached the delay");
    drop_fast_a: assert property (@(posedge clk_sys) disable iff (rst)
        !request |=> !delayed)
        else $error("delayed output stayed active after the request dropped");
    count_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(request) |-> state.count == '0)
        else $error("delay counter did not restart on a new active edge");
endmodule

// [hw/bridge_pwm_output_steering.sv]
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "steer_consts.svh"

module bridge_pwm_output_steering #(
    parameter int DELAY_WIDTH = 7
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave.
    input wire steer_pkg::apb_req_t apbReq,
    output steer_pkg::apb_rsp_t apbRsp,
    // PWM waveform from the timebase.
    input wire logic pwmIn,
    // Steering outputs and their drive enables.
    output steer_pkg::steer_pins_t steerOut,
    output steer_pkg::steer_pins_t steerDrive
);
    import steer_pkg::*;

    typedef struct packed {
        steer_cfg_t cfg;
        apb_rsp_t rsp;
        steer_pins_t pins;
        steer_pins_t drive;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;
    logic delayedA;
    logic delayedB;
    logic busyA;
    logic busyB;
    logic halfMode;
    logic reqA;
    logic reqB;
    logic [DELAY_WIDTH-1:0] delayCfg;
    logic access;
    steer_pins_t raw;
    steer_pins_t drv;

    initial
    begin
        if (DELAY_WIDTH != `CTL_DELAY_MSB - `CTL_DELAY_LSB + 1)
        begin
            $error("bridge_pwm_output_steering: DELAY_WIDTH must match the delay field");
        end
    end

    assign halfMode = (state.cfg.mode == MODE_HALF);
    assign reqA = halfMode & pwmIn;
    assign reqB = halfMode & ~pwmIn;
    assign delayCfg = state.cfg.delay;
    assign access = apbReq.psel & apbReq.penable;

    deadband_delay #(.DELAY_WIDTH(DELAY_WIDTH)) delayA (
        .clk_sys(clk_sys),
        .rst(rst),
        .request(reqA),
        .delay(delayCfg),
        .delayed(delayedA),
        .busy(busyA)
    );

    deadband_delay #(.DELAY_WIDTH(DELAY_WIDTH)) delayB (
        .clk_sys(clk_sys),
        .rst(rst),
        .request(reqB),
        .delay(delayCfg),
        .delayed(delayedB),
        .busy(busyB)
    );

    // Active level logic; the pin polarity is applied afterwards.
    always_comb
    begin
        raw = '0;
        drv = '0;
        unique case (state.cfg.mode)
            MODE_SINGLE:
            begin
                raw.a = pwmIn;
                drv.a = 1'b1;
            end
            MODE_HALF:
            begin
                raw.a = delayedA;
                raw.b = delayedB;
                drv.a = 1'b1;
                drv.b = 1'b1;
            end
            MODE_FULL:
            begin
                drv = '1;
                if (state.cfg.reverse)
                begin
                    raw.c = 1'b1;
                    raw.b = pwmIn;
                end
                else
                begin
                    raw.a = 1'b1;
                    raw.d = pwmIn;
                end
            end
            default:
            begin
                raw = '0;
                drv = '0;
            end
        endcase
    end

    always_comb
    begin
        next_state = state;
        next_state.rsp.pready = 1'b0;
        next_state.rsp.pslverr = 1'b0;
        next_state.rsp.prdata = `UNMAPPED_DATA;
        if (apbReq.psel && !apbReq.penable)
        begin
            next_state.rsp.pready = 1'b1;
            if (!apbReq.pwrite)
            begin
                unique case (apbReq.paddr)
                    `ADDR_CONTROL:
                    begin
                        next_state.rsp.prdata[`CTL_DELAY_MSB:`CTL_DELAY_LSB] = state.cfg.delay;
                        next_state.rsp.prdata[`CTL_MODE_MSB:`CTL_MODE_LSB] = state.cfg.mode;
                        next_state.rsp.prdata[`CTL_DIR_BIT] = state.cfg.reverse;
                        next_state.rsp.prdata[`CTL_ACTIVE_LOW_BIT] = state.cfg.activeLow;
                    end
                    `ADDR_STATUS:
                    begin
                        next_state.rsp.prdata[`STA_OUT_MSB:`STA_OUT_LSB] = state.pins;
                        next_state.rsp.prdata[`STA_DELAY_BUSY_BIT] = busyA | busyB;
                    end
                    default:
                    begin
                        next_state.rsp.pslverr = 1'b1;
                    end
                endcase
            end
            else if (apbReq.paddr != `ADDR_CONTROL && apbReq.paddr != `ADDR_STATUS)
            begin
                next_state.rsp.pslverr = 1'b1;
            end
        end
        // Writes land at the edge where the master sees pready.
        if (access && state.rsp.pready && apbReq.pwrite && apbReq.paddr == `ADDR_CONTROL)
        begin
            next_state.cfg.delay = apbReq.pwdata[`CTL_DELAY_MSB:`CTL_DELAY_LSB];
            next_state.cfg.mode = (apbReq.pwdata[`CTL_MODE_MSB:`CTL_MODE_LSB] == 2'h3)
                ? MODE_SINGLE
                : steer_mode_t'(apbReq.pwdata[`CTL_MODE_MSB:`CTL_MODE_LSB]);
            next_state.cfg.reverse = apbReq.pwdata[`CTL_DIR_BIT];
            next_state.cfg.activeLow = apbReq.pwdata[`CTL_ACTIVE_LOW_BIT];
        end
        // Undriven pins rest at their inactive level so a late enable causes no glitch.
        next_state.pins = raw ^ {4{state.cfg.activeLow}};
        next_state.drive = drv;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign apbRsp = state.rsp;
    assign steerOut = state.pins;
    assign steerDrive = state.drive;

    complement_half_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state.cfg.mode == MODE_HALF && $past(state.cfg.mode) == MODE_HALF && $stable(state.cfg))
        |-> !((steerOut.a ^ state.cfg.activeLow) && (steerOut.b ^ state.cfg.activeLow)))
        else $error("both half-bridge outputs active together");
    half_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
        (halfMode && $rose(reqA) && delayCfg == 7'h03) ##1 (reqA && halfMode)[*4]
        |-> !(state.pins.a ^ state.cfg.activeLow) ##1 (state.pins.a ^ state.cfg.activeLow))
        else $error("half-bridge output A did not honour a three cycle dead band");
    full_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(state.cfg.mode) == MODE_FULL |-> steerDrive == 4'hF)
        else $error("full-bridge mode left a pin undriven");
    forward_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state.cfg.mode == MODE_FULL && !state.cfg.reverse && !state.cfg.activeLow)
        |=> $past(state.cfg) != state.cfg
            || (steerOut.a && !steerOut.b && !steerOut.c && steerOut.d == $past(pwmIn)))
        else $error("forward pattern wrong");
    reverse_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state.cfg.mode == MODE_FULL && state.cfg.reverse && !state.cfg.activeLow)
        |=> $past(state.cfg) != state.cfg
            || (steerOut.c && !steerOut.a && !steerOut.d && steerOut.b == $past(pwmIn)))
        else $error("reverse pattern wrong");
    apb_ready_a: assert property (@(posedge clk_sys) disable iff (rst)
        (apbReq.psel && !apbReq.penable) |=> apbRsp.pready)
        else $error("APB access phase not answered in one cycle");
    half_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(state.cfg.mode) == MODE_HALF |-> steerDrive == 4'hC)
        else $error("half-bridge mode did not drive exactly outputs A and B");
    single_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(state.cfg.mode) == MODE_SINGLE
        |-> steerOut.a == ($past(pwmIn) ^ $past(state.cfg.activeLow)))
        else $error("single output A did not follow the waveform");
    undriven_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        ((steerOut ^ {4{$past(state.cfg.activeLow)}}) & ~steerDrive) == 4'h0)
        else $error("an undriven pin left its inactive level");
endmodule

// [tb/bridge_driver_model.sv]
`timescale 1ns/1ps
module bridge_driver_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Pins from the steering stage.
    input wire steer_pkg::steer_pins_t steerOut,
    input wire steer_pkg::steer_pins_t steerDrive,
    // Supervision.
    input wire logic watch,
    output logic shootThrough
);
    import steer_pkg::*;
    // A switch conducts only while its pin is driven, so an undriven pin keeps it off.
    logic onA;
    logic onB;
    assign onA = steerDrive.a & steerOut.a;
    assign onB = steerDrive.b & steerOut.b;
    // Both switches of one leg on at once would short the supply; that is latched.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            shootThrough <= 1'b0;
        else if (watch && onA && onB)
            shootThrough <= 1'b1;
    end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "steer_consts.svh"
module tb_top;
    import steer_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    apb_req_t apbReq = '0;
    apb_rsp_t apbRsp;
    logic pwmIn = 1'b0;
    logic watch = 1'b0;
    steer_pins_t steerOut;
    steer_pins_t steerDrive;
    logic shootThrough;
    int badCount = 0;
    int nChecks = 0;
    logic [31:0] seed = 32'hA38C;
    logic [31:0] rdata;
    logic rerr;
    always #20 clk_sys = ~clk_sys;
    bridge_pwm_output_steering #(.DELAY_WIDTH(7)) dut (.clk_sys(clk_sys), .rst(rst),
        .apbReq(apbReq), .apbRsp(apbRsp), .pwmIn(pwmIn), .steerOut(steerOut),
        .steerDrive(steerDrive));
    bridge_driver_model partner (.clk_sys(clk_sys), .rst(rst), .steerOut(steerOut),
        .steerDrive(steerDrive), .watch(watch), .shootThrough(shootThrough));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] expect_pins(input logic [1:0] m, input logic rv,
        input logic al, input logic p);
        if (m == 2'h2)
            return {4'hF, (rv ? {1'b0, p, 2'b10} : {3'b100, p}) ^ {4{al}}};
        return {4'h8, {p, 3'b000} ^ {4{al}}};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            badCount++;
        end
    endtask
    // Call right after a rising edge; the request is held until pready is seen.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        // Right after the edge the registered answer still shows what the edge sampled.
        rdata = apbRsp.prdata;
        rerr = apbRsp.pslverr;
        apbReq <= '0;
        // One idle edge keeps the next call from assigning the request in this time step.
        @(posedge clk_sys);
        if (n >= 20)
            check("pready", 32'h1, 32'h0);
    endtask
    task automatic half_pulse(input int d, input int len);
        repeat (d + 8) @(posedge clk_sys);
        @(negedge clk_sys);
        check("half idle", 32'hC4, {24'h0, steerDrive, steerOut});
        for (int k = 1; k <= len + d + 6; k++)
        begin
            @(posedge clk_sys);
            pwmIn <= (k <= len);
            @(negedge clk_sys);
            if (k <= d + 2 || len <= d || k >= len + 4)
                check("a off", 32'h0, {31'h0, steerOut.a});
            if (k >= d + 5 && k <= len && len > d)
                check("a on", 32'h1, {31'h0, steerOut.a});
            if (k >= 3 && k <= len + d + 2)
                check("b off", 32'h0, {31'h0, steerOut.b});
            if (k >= len + d + 5)
                check("b on", 32'h1, {31'h0, steerOut.b});
        end
        @(posedge clk_sys);
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        finishTest;
    end
    initial
    begin
        logic [31:0] cw;
        logic [7:0] ex;
        logic [1:0] md;
        logic al;
        logic last;
        int d;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, `ADDR_CONTROL, 32'h0);
        check("control reset", `CONTROL_RESET, rdata);
        apb(1'b1, 12'h008, 32'h0000_0F7F);
        check("unmapped err", 32'h1, {31'h0, rerr});
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped data", `UNMAPPED_DATA, rdata);
        cw = rnd() & 32'h0000_0F7F;
        apb(1'b1, `ADDR_CONTROL, cw);
        apb(1'b0, `ADDR_CONTROL, 32'h0);
        // Mode code 3 is served as single output and reads back as 0.
        check("control", (cw[9:8] == 2'h3) ? (cw & 32'hFFFF_FCFF) : cw, rdata);
        for (int m = 0; m < 8; m++)
        begin
            md = (m[1:0] == 2'h1) ? 2'h2 : m[1:0];
            al = (rnd() & 32'h1) != 32'h0;
            apb(1'b1, `ADDR_CONTROL, {20'h0, al, m[2], md, 8'h00});
            for (int i = 0; i < 12; i++)
            begin
                @(posedge clk_sys);
                last = pwmIn;
                pwmIn <= (rnd() & 32'h1) != 32'h0;
                @(negedge clk_sys);
                ex = expect_pins(md, m[2], al, last);
                check("pins", {24'h0, ex}, {24'h0, steerDrive, steerOut});
            end
            @(posedge clk_sys);
            apb(1'b0, `ADDR_STATUS, 32'h0);
            ex = expect_pins(md, m[2], al, pwmIn);
            check("status", {28'h0, ex[3:0]}, rdata & 32'h1F);
        end
        @(posedge clk_sys);
        pwmIn <= 1'b0;
        watch <= 1'b1;
        for (int t = 0; t < 6; t++)
        begin
            // Corner cases first: the widest delay, then the three-cycle delay.
            d = (t == 0) ? 127 : (t == 1) ? 3 : 1 + int'(rnd() % 12);
            apb(1'b1, `ADDR_CONTROL, {22'h0, 2'h1, 1'b0, d[6:0]});
            half_pulse(d, 1 + int'(rnd() % d));
            half_pulse(d, d + 8);
        end
        // A pulse still counting its dead band must show the counter busy.
        apb(1'b1, `ADDR_CONTROL, 32'h0000_017F);
        pwmIn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("busy", 32'h10, rdata & 32'h1F);
        pwmIn <= 1'b0;
        check("shoot through", 32'h0, {31'h0, shootThrough});
        finishTest;
    end
endmodule
